//--- verilog/host_link_pkg.sv
// shared constants and carriers for the host/target link interpreter
`default_nettype none
package host_link_pkg;
  localparam logic [3:0] OP_LINK_SETUP = 4'h8;
  localparam logic [3:0] OP_HOST_TO_TARGET = 4'h9;
  localparam logic [3:0] OP_TARGET_TO_HOST = 4'ha;
  localparam logic [3:0] OP_SET_OPTIONS = 4'hb;
  localparam int MOD_ALT_BIT = 7;
  localparam int MOD_INIT_BIT = 6;
  localparam int MOD_SUPPRESS_BIT = 5;
  localparam int MOD_NOTIFY_BIT = 4;
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_ALL_DEFER_BIT = 6;
  localparam int MODE_IRQ_HIGH_BIT = 3;
  localparam logic [7:0] RSP_DONE = 8'h80;
  localparam logic [7:0] RSP_ERR = 8'h10;
  localparam logic [7:0] ERR_NO_LINK = 8'hff;
  localparam logic [7:0] ERR_BUSY = 8'hfe;
  localparam logic [7:0] ERR_TIMEOUT = 8'hfd;
  localparam logic [7:0] ERR_OVERRUN = 8'hfc;
  localparam logic [7:0] ERR_NO_DATA = 8'hfb;
  localparam logic [7:0] LINK_COUNT = 8'h03;
  localparam logic [7:0] BLOCK_FIXED0 = 8'h01;
  localparam logic [7:0] BLOCK_FIXED1 = 8'h00;
  localparam logic [1:0] BLOCK_HOST_DATA = 2'h2;
  localparam logic [1:0] BLOCK_STATUS = 2'h3;
  localparam logic [7:0] MODE_RESET = 8'h80;
  localparam int TIMEOUT_US = 100;
  localparam int CLK_MHZ = 50;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int BUF_DEPTH = 16;
  localparam int BUF_WIDTH = 8;
  localparam int IRQ_PULSE_CYCLES = 4;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;

  // port to the emulation memory holding the four-byte exchange block
  typedef struct packed {
    logic wr;
    logic [23:0] addr;
    logic [7:0] data;
  } block_write_t;
endpackage
`default_nettype wire

//--- verilog/byte_fifo.sv
// synchronous FIFO with valid/ready on both sides
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;
  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t st_r, st_nxt;
  logic push, pop;

  assign in_ready_out = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st_r.cnt != '0);
  assign out_data_out = mem[st_r.rp];
  assign level_out = st_r.cnt;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (pop) st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (clear_in) st_nxt = '0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) st_r <= '0;
    else st_r <= st_nxt;
    if (push) mem[st_r.wp] <= in_data_in;
  end
endmodule
`default_nettype wire

//--- verilog/link_cmd_engine.sv
// command interpreter for the host/target byte-channel link
`default_nettype none
module link_cmd_engine
  import host_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire byte_beat_t host_rx_in,
  output logic host_rx_ready_out,
  output byte_beat_t host_tx_out,
  input wire logic host_tx_ready_in,
  input wire logic target_byte_ready_in,
  input wire logic [7:0] target_byte_in,
  output logic target_byte_ack_out,
  input wire logic host_byte_taken_in,
  output block_write_t block_wr_out,
  output logic target_irq_out,
  output logic [7:0] mode_out,
  output logic [23:0] block_addr_out,
  output logic [7:0] status_out
);
  typedef enum logic [3:0] {
    S_ID, S_CMD, S_CNT, S_DATA, S_EXEC, S_REPLY, S_IDLE
  } phase_t;

  typedef struct packed {
    phase_t ph;
    logic [7:0] id;
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [7:0] left;
    logic [23:0] addr;
    logic [7:0] mode;
    logic linked;
    logic tbr;
    logic hbr;
    logic [7:0] wr_left;
    logic wr_defer;
    logic [7:0] wr_cmd;
    logic rd_pend;
    logic [7:0] rd_cmd;
    logic [15:0] tmo;
    logic [3:0][7:0] rsp;
    logic [2:0] rsp_len;
    logic [2:0] rsp_idx;
    logic rsp_data;
    logic [4:0] data_left;
    logic irq_req;
    logic [2:0] irq_cnt;
    logic [1:0] sync0;
    logic [1:0] sync1;
    logic blk_wr;
    logic [1:0] blk_sel;
    logic [7:0] blk_data;
    logic in_buf_dir;
    logic tgt_rdy_d;
    logic take_d;
    logic [1:0] init_left;
  } eng_state_t;

  eng_state_t st_r, st_nxt;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_in_data, fifo_out_data;
  logic [4:0] fifo_level;
  logic fifo_clear;
  logic tgt_rdy_s, host_take_s;
  logic tgt_rise, take_rise;

  function automatic logic [7:0] status_of(input logic t, input logic h);
    status_of = {4'h0, 2'b00, h, t};
  endfunction

  function automatic logic [7:0] rsp_cmd(input logic [7:0] c,
                                         input logic e);
    rsp_cmd = RSP_DONE | (e ? RSP_ERR : 8'h00) | {4'h0, c[3:0]};
  endfunction

  // the internal buffer: holds write data or received target data
  byte_fifo #(.WIDTH(BUF_WIDTH), .DEPTH(BUF_DEPTH)) buf_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(fifo_clear),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .level_out(fifo_level)
  );

  assign tgt_rdy_s = st_r.sync0[1];
  assign host_take_s = st_r.sync1[1];
  // one event per rising edge; the synchroniser lags the pin two clocks
  assign tgt_rise = tgt_rdy_s && !st_r.tgt_rdy_d;
  assign take_rise = host_take_s && !st_r.take_d;
  assign status_out = status_of(st_r.tbr, st_r.hbr);
  assign mode_out = st_r.mode;
  assign block_addr_out = st_r.addr;
  assign target_byte_ack_out = st_r.tbr && fifo_in_ready &&
    !st_r.in_buf_dir && st_r.ph == S_IDLE;
  assign host_rx_ready_out = (st_r.ph == S_ID) || (st_r.ph == S_CMD) ||
    (st_r.ph == S_CNT) || (st_r.ph == S_DATA && (fifo_in_ready ||
    st_r.cmd[3:0] != OP_HOST_TO_TARGET));
  assign block_wr_out = '{wr: st_r.blk_wr,
    addr: st_r.addr + {22'h0, st_r.blk_sel}, data: st_r.blk_data};
  assign target_irq_out = (st_r.irq_cnt != 3'h0) ^
    !st_r.mode[MODE_IRQ_HIGH_BIT];

  always_comb begin
    logic [3:0] op;
    logic err;
    st_nxt = st_r;
    op = st_r.cmd[3:0];
    err = 1'b0;
    fifo_clear = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data = 8'h00;
    fifo_out_ready = 1'b0;
    host_tx_out = '{valid: 1'b0, data: 8'h00};
    st_nxt.blk_wr = 1'b0;
    st_nxt.irq_req = 1'b0;
    st_nxt.sync0 = {st_r.sync0[0], target_byte_ready_in};
    st_nxt.sync1 = {st_r.sync1[0], host_byte_taken_in};
    st_nxt.tgt_rdy_d = tgt_rdy_s;
    st_nxt.take_d = host_take_s;
    if (st_r.irq_cnt != 3'h0) st_nxt.irq_cnt = st_r.irq_cnt - 3'h1;
    if (st_r.irq_req) st_nxt.irq_cnt = 3'(IRQ_PULSE_CYCLES);
    // block status tracking; a new event beats the clear
    if (take_rise) st_nxt.hbr = 1'b0;
    if (tgt_rise) st_nxt.tbr = 1'b1;
    case (st_r.ph)
      S_ID: if (host_rx_in.valid) begin
        st_nxt.id = host_rx_in.data;
        st_nxt.ph = S_CMD;
      end else begin
        st_nxt.ph = S_IDLE; // no host byte: run a scheduling pass
      end
      S_CMD: if (host_rx_in.valid) begin
        st_nxt.cmd = host_rx_in.data;
        st_nxt.ph = S_CNT;
      end
      S_CNT: if (host_rx_in.valid) begin
        st_nxt.cnt = host_rx_in.data;
        st_nxt.left = host_rx_in.data;
        st_nxt.addr = (op == OP_LINK_SETUP) ? 24'h0 : st_r.addr;
        if (op == OP_HOST_TO_TARGET && (st_r.wr_left != 8'h0 ||
            st_r.in_buf_dir == 1'b0 && fifo_level != 5'h0)) begin
          st_nxt.wr_cmd = 8'hff; // marks busy refusal, data drained
        end else if (op == OP_HOST_TO_TARGET) begin
          st_nxt.wr_cmd = st_r.cmd;
          fifo_clear = 1'b1;
          st_nxt.in_buf_dir = 1'b1;
        end
        st_nxt.ph = (host_rx_in.data == 8'h0) ? S_EXEC : S_DATA;
      end
      S_DATA: if (host_rx_ready_out && host_rx_in.valid) begin
        st_nxt.left = st_r.left - 8'h1;
        if (op == OP_LINK_SETUP && st_r.cnt == LINK_COUNT)
          st_nxt.addr = {st_r.addr[15:0], host_rx_in.data};
        if (op == OP_SET_OPTIONS && st_r.cmd[MOD_INIT_BIT])
          st_nxt.mode = host_rx_in.data;
        if (op == OP_HOST_TO_TARGET && st_r.wr_cmd != 8'hff) begin
          fifo_in_valid = 1'b1;
          fifo_in_data = host_rx_in.data;
        end
        if (st_r.left == 8'h1) st_nxt.ph = S_EXEC;
      end
      S_EXEC: begin
        st_nxt.rsp[0] = st_r.id;
        st_nxt.rsp_idx = 3'h0;
        st_nxt.rsp_data = 1'b0;
        st_nxt.rsp_len = 3'h4;
        st_nxt.rsp[3] = 8'h00;
        st_nxt.rsp[2] = 8'h01;
        st_nxt.ph = S_REPLY;
        if (st_r.cmd[MOD_ALT_BIT]) begin
          err = 1'b1;
          st_nxt.rsp[3] = ERR_NO_LINK;
        end else case (op)
          OP_LINK_SETUP: begin
            if (st_r.cnt != LINK_COUNT) begin
              err = 1'b1;
              st_nxt.rsp[3] = ERR_NO_LINK;
            end else begin
              st_nxt.linked = 1'b1;
              if (st_r.cmd[MOD_INIT_BIT]) begin
                st_nxt.tbr = 1'b0;
                st_nxt.hbr = 1'b0;
                st_nxt.wr_left = 8'h0;
                st_nxt.rd_pend = 1'b0;
                fifo_clear = 1'b1;
                st_nxt.init_left = 2'h3;
              end
            end
          end
          OP_HOST_TO_TARGET: begin
            if (st_r.wr_cmd == 8'hff || !st_r.mode[MODE_ENABLE_BIT]) begin
              err = 1'b1;
              st_nxt.rsp[2] = 8'h02;
              st_nxt.rsp[3] = (st_r.wr_cmd == 8'hff) ? ERR_BUSY :
                ERR_NO_LINK;
              st_nxt.rsp_len = 3'h5;
              if (st_r.wr_cmd != 8'hff) begin
                fifo_clear = 1'b1;
                st_nxt.in_buf_dir = 1'b0; // refused data leaves the buffer
              end
            end else begin
              st_nxt.wr_left = 5'(fifo_level) == 5'h0 ? 8'h0 :
                {3'h0, fifo_level};
              st_nxt.wr_defer = st_r.cmd[MOD_INIT_BIT];
              st_nxt.tmo = 16'(TIMEOUT_CYCLES);
              st_nxt.irq_req = st_r.cmd[MOD_NOTIFY_BIT];
            end
            st_nxt.wr_cmd = st_r.cmd;
          end
          OP_TARGET_TO_HOST: begin
            if (st_r.in_buf_dir || fifo_level == 5'h0) begin
              if (st_r.cmd[MOD_INIT_BIT] || st_r.mode[MODE_ALL_DEFER_BIT])
              begin
                st_nxt.rd_pend = 1'b1;
                st_nxt.rd_cmd = st_r.cmd;
                st_nxt.ph = S_IDLE;
              end else begin
                err = 1'b1;
                st_nxt.rsp[2] = 8'h02;
                st_nxt.rsp[3] = ERR_NO_DATA;
                st_nxt.rsp_len = 3'h5;
              end
            end else begin
              st_nxt.rsp[2] = {3'h0, fifo_level};
              st_nxt.rsp_len = 3'h3;
              st_nxt.rsp_data = 1'b1;
              st_nxt.data_left = fifo_level;
            end
          end
          OP_SET_OPTIONS: begin
            if (!st_r.cmd[MOD_INIT_BIT]) st_nxt.irq_req = 1'b1;
          end
          default: begin
            err = 1'b1;
            st_nxt.rsp[3] = ERR_NO_LINK;
          end
        endcase
        st_nxt.rsp[1] = rsp_cmd(st_r.cmd, err);
        st_nxt.rsp[4 - 4] = st_r.id;
        if (st_r.cmd[MOD_NOTIFY_BIT] && op != OP_HOST_TO_TARGET &&
            op != OP_TARGET_TO_HOST) st_nxt.irq_req = 1'b1;
        if (st_r.cmd[MOD_SUPPRESS_BIT] && st_nxt.ph == S_REPLY)
          st_nxt.ph = S_IDLE;
      end
      S_REPLY: if (host_tx_ready_in) begin
        if (st_r.rsp_idx == st_r.rsp_len - 3'h1 && st_r.rsp_idx == 3'h4)
          host_tx_out = '{valid: 1'b1,
            data: status_of(st_r.tbr, st_r.hbr)};
        else if (st_r.rsp_idx < st_r.rsp_len)
          host_tx_out = '{valid: 1'b1, data: st_r.rsp[st_r.rsp_idx[1:0]]};
        else if (st_r.rsp_data && st_r.data_left != 5'h0) begin
          host_tx_out = '{valid: fifo_out_valid, data: fifo_out_data};
          fifo_out_ready = 1'b1;
        end
        if (st_r.rsp_idx < st_r.rsp_len) st_nxt.rsp_idx = st_r.rsp_idx + 3'h1;
        else if (fifo_out_valid && st_r.data_left != 5'h0)
          st_nxt.data_left = st_r.data_left - 5'h1;
        if ((st_r.rsp_idx == st_r.rsp_len - 3'h1 && !st_r.rsp_data) ||
            (st_r.rsp_idx == st_r.rsp_len && st_r.data_left == 5'h1)) begin
          st_nxt.ph = S_IDLE;
          if (st_r.rsp_data && st_r.rsp[1][MOD_NOTIFY_BIT - 4 + 4] == 1'b0
              && st_r.cmd[MOD_NOTIFY_BIT]) st_nxt.irq_req = 1'b1;
        end
      end
      S_IDLE: begin
        // one scheduling pass over the exchange block status
        st_nxt.ph = S_ID;
        if (st_r.wr_left != 8'h0 && st_r.in_buf_dir) begin
          if (!st_r.hbr && fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            st_nxt.blk_wr = 1'b1;
            st_nxt.blk_sel = BLOCK_HOST_DATA;
            st_nxt.blk_data = fifo_out_data;
            st_nxt.hbr = 1'b1;
            st_nxt.wr_left = st_r.wr_left - 8'h1;
            st_nxt.tmo = 16'(TIMEOUT_CYCLES);
            if (st_r.wr_left == 8'h1 && st_r.wr_defer) begin
              st_nxt.rsp[0] = st_r.id;
              st_nxt.rsp[1] = rsp_cmd(st_r.wr_cmd, 1'b0);
              st_nxt.rsp[2] = 8'h01;
              st_nxt.rsp[3] = 8'h00;
              st_nxt.rsp_len = 3'h4;
              st_nxt.rsp_idx = 3'h0;
              st_nxt.rsp_data = 1'b0;
              st_nxt.ph = S_REPLY;
            end
            if (st_r.wr_left == 8'h1) st_nxt.in_buf_dir = 1'b0;
          end else if (st_r.tmo == 16'h1) begin
            st_nxt.wr_left = 8'h0;
            st_nxt.in_buf_dir = 1'b0;
            fifo_clear = 1'b1;
            if (st_r.wr_defer) begin
              st_nxt.rsp[0] = st_r.id;
              st_nxt.rsp[1] = rsp_cmd(st_r.wr_cmd, 1'b1);
              st_nxt.rsp[2] = 8'h02;
              st_nxt.rsp[3] = ERR_TIMEOUT;
              st_nxt.rsp_len = 3'h5;
              st_nxt.rsp_idx = 3'h0;
              st_nxt.rsp_data = 1'b0;
              st_nxt.ph = S_REPLY;
            end
          end else st_nxt.tmo = st_r.tmo - 16'h1;
        end else if (st_r.tbr && fifo_in_ready && !st_r.in_buf_dir) begin
          fifo_in_valid = 1'b1;
          fifo_in_data = target_byte_in;
          st_nxt.tbr = tgt_rise;
          if (st_r.rd_pend) begin
            st_nxt.rd_pend = 1'b0;
            st_nxt.rsp[0] = st_r.id;
            st_nxt.rsp[1] = rsp_cmd(st_r.rd_cmd, 1'b0);
            st_nxt.rsp[2] = 8'h01;
            st_nxt.rsp_len = 3'h3;
            st_nxt.rsp_idx = 3'h0;
            st_nxt.rsp_data = 1'b1;
            st_nxt.data_left = 5'h1;
            st_nxt.ph = S_REPLY;
          end
        end
      end
      default: st_nxt.ph = S_ID;
    endcase
    // fixed bytes, then status; waits while a host-data write owns the port
    if (st_r.init_left != 2'h0 && !st_nxt.blk_wr) begin
      st_nxt.blk_wr = 1'b1;
      st_nxt.blk_sel = (st_r.init_left == 2'h1) ? BLOCK_STATUS :
        ~st_r.init_left;
      st_nxt.blk_data = (st_r.init_left == 2'h3) ? BLOCK_FIXED0 :
        (st_r.init_left == 2'h2) ? BLOCK_FIXED1 :
        status_of(st_r.tbr, st_r.hbr);
      st_nxt.init_left = st_r.init_left - 2'h1;
    end
    if (!st_r.mode[MODE_ENABLE_BIT]) st_nxt.tbr = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.ph <= S_ID;
      st_r.mode <= MODE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

//--- testbench/link_cmd_props.sv
// assertions on the link command interpreter ports
`default_nettype none
module link_cmd_props
  import host_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire byte_beat_t host_rx_in,
  input wire logic host_rx_ready_out,
  input wire byte_beat_t host_tx_out,
  input wire logic host_tx_ready_in,
  input wire logic target_byte_ready_in,
  input wire logic [7:0] target_byte_in,
  input wire logic target_byte_ack_out,
  input wire logic host_byte_taken_in,
  input wire block_write_t block_wr_out,
  input wire logic target_irq_out,
  input wire logic [7:0] mode_out,
  input wire logic [23:0] block_addr_out,
  input wire logic [7:0] status_out
);
  logic act;
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] off;
  logic [7:0] tx_idx, tx_len;
  assign act = target_irq_out == mode_out[MODE_IRQ_HIGH_BIT];
  assign off = block_wr_out.addr - block_addr_out;
  // position of the current byte inside a reply
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_idx <= 8'h00;
      tx_len <= 8'h00;
    end else if (host_tx_out.valid && host_tx_ready_in) begin
      if (tx_idx == 8'h02) tx_len <= host_tx_out.data + 8'h02;
      if (tx_idx > 8'h02 && tx_idx == tx_len) tx_idx <= 8'h00;
      else tx_idx <= tx_idx + 8'h01;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reset_vals_a: assert property (
    $fell(rst_in) |-> mode_out == MODE_RESET && status_out == 8'h00
      && target_irq_out) else $error("wrong state after reset");
  status_zero_a: assert property (
    status_out[7:2] == 6'h00) else $error("status high bits set");
  block_range_a: assert property (
    block_wr_out.wr |-> off < 24'h4) else $error("write outside block");
  block_fixed_a: assert property (
    block_wr_out.wr && off < 24'h2 |-> block_wr_out.data ==
      (off == 24'h0 ? BLOCK_FIXED0 : BLOCK_FIXED1))
    else $error("fixed block bytes wrong");
  block_status_a: assert property (
    block_wr_out.wr && off == 24'h3 |-> block_wr_out.data[3:2] == 2'h0)
    else $error("stored status bits 2-3 set");
  host_ready_a: assert property (
    block_wr_out.wr && off == 24'h2 |-> ##[0:2] status_out[1])
    else $error("host byte ready not set");
  target_ack_a: assert property (
    target_byte_ack_out |-> status_out[0])
    else $error("target byte read without ready bit");
  frame_serial_a: assert property (
    host_tx_out.valid |-> !host_rx_ready_out)
    else $error("host input accepted during reply");
  reply_done_a: assert property (
    host_tx_out.valid && tx_idx == 8'h01 |-> host_tx_out.data[7])
    else $error("reply done bit missing");
  irq_pulse_a: assert property (
    $rose(act) && $stable(mode_out) |-> act [*4] ##1 !act)
    else $error("target interrupt pulse length wrong");
endmodule
`default_nettype wire

//--- testbench/host_model.sv
// host side model: sends command frames, collects reply bytes
`default_nettype none
module host_model
  import host_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic slow_in,
  output byte_beat_t rx_out,
  input wire logic rx_ready_in,
  input wire byte_beat_t tx_in,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  initial begin
    rx_out = '0;
    tx_ready_out = 1'b1;
  end
  // slow host accepts a reply byte every other cycle
  always @(negedge clk_in) begin
    tx_ready_out <= !slow_in || !tx_ready_out;
  end
  always @(posedge clk_in) begin
    if (tx_in.valid && tx_ready_out) begin
      got_q.push_back(tx_in.data);
    end
  end
  // id, op byte, count, then exactly count data bytes
  task automatic send(input logic [7:0] f[$]);
    int w;
    foreach (f[i]) begin
      @(negedge clk_in);
      rx_out.valid = 1'b1;
      rx_out.data = f[i];
      w = 0;
      do @(posedge clk_in); while (!rx_ready_in && ++w < 1000);
    end
    @(negedge clk_in);
    rx_out.valid = 1'b0;
    rx_out.data = ~rx_out.data;
  endtask
endmodule
`default_nettype wire

//--- testbench/link_cmd_engine_bench.sv
// self-checking bench for the link command interpreter
`default_nettype none
module link_cmd_engine_bench
  import host_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] BASE = 24'h123456;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic slow = 1'b0;
  logic reader_on = 1'b1;
  logic t_ready = 1'b0;
  logic [7:0] t_data = 8'h00;
  logic taken = 1'b0;
  logic acked = 1'b0;
  logic irq_seen = 1'b0;
  logic [7:0] host_data = 8'h00;
  byte_beat_t rx;
  byte_beat_t tx;
  logic rx_ready, tx_ready, t_ack, irq;
  block_write_t blk;
  logic [7:0] mode, status;
  logic [23:0] addr_seen;
  int n_fail = 0;
  int total_checks = 0;
  always #10 clk_in = ~clk_in;
  // target model: reads host byte when flagged, drops its byte once read
  always @(negedge clk_in) begin
    taken <= reader_on && status[1];
    if (acked && t_ready) begin
      t_ready <= 1'b0;
      t_data <= ~t_data;
    end
  end
  always @(posedge clk_in) begin
    acked <= t_ack;
    if (irq) irq_seen <= 1'b1;
    if (blk.wr && blk.addr == BASE + 24'h2) host_data <= blk.data;
  end
  link_cmd_engine dut (.clk_in(clk_in), .rst_in(rst_in), .host_rx_in(rx),
    .host_rx_ready_out(rx_ready), .host_tx_out(tx),
    .host_tx_ready_in(tx_ready), .target_byte_ready_in(t_ready),
    .target_byte_in(t_data), .target_byte_ack_out(t_ack),
    .host_byte_taken_in(taken), .block_wr_out(blk),
    .target_irq_out(irq), .mode_out(mode), .block_addr_out(addr_seen),
    .status_out(status));
  host_model host (.clk_in(clk_in), .slow_in(slow), .rx_out(rx),
    .rx_ready_in(rx_ready), .tx_in(tx), .tx_ready_out(tx_ready));
  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic reply(input logic [7:0] e[$]);
    int w = 0;
    while (host.got_q.size() < e.size() && w++ < 12000) @(posedge clk_in);
    foreach (e[i]) begin
      chk("reply byte", e[i],
        host.got_q.size() ? host.got_q.pop_front() : 8'hxx);
    end
    repeat (4) @(posedge clk_in);
  endtask
  task automatic tsend(input logic [7:0] b);
    @(negedge clk_in);
    t_ready <= 1'b1;
    t_data <= b;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #800000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    host.send('{8'h00, 8'h48, 8'h03, 8'h12, 8'h34, 8'h56});
    reply('{8'h00, 8'h88, 8'h01, 8'h00});
    chk("block address", BASE, addr_seen);
    chk("mode", MODE_RESET, mode);
    done("link");
    host.send('{8'h00, 8'h09, 8'h01, 8'h55});
    reply('{8'h00, 8'h89, 8'h01, 8'h00});
    repeat (20) @(posedge clk_in);
    chk("host data", 8'h55, host_data);
    host.send('{8'h00, 8'h39, 8'h01, 8'h66});
    repeat (30) @(posedge clk_in);
    chk("reply count", 0, host.got_q.size());
    chk("host data", 8'h66, host_data);
    host.send('{8'h00, 8'h69, 8'h02, 8'ha1, 8'ha2});
    reply('{8'h00, 8'h89, 8'h01, 8'h00});
    chk("host data", 8'ha2, host_data);
    done("write");
    reader_on = 1'b0;
    host.send('{8'h00, 8'h49, 8'h02, 8'h77, 8'h78});
    reply('{8'h00, 8'h89, 8'h01, 8'h00});
    reply('{8'h00, 8'h99, 8'h02, ERR_TIMEOUT, 8'h02});
    host.send('{8'h00, 8'h09, 8'h03, 8'h01, 8'h02, 8'h03});
    reply('{8'h00, 8'h89, 8'h01, 8'h00});
    host.send('{8'h00, 8'h09, 8'h01, 8'h04});
    reply('{8'h00, 8'h99, 8'h02, ERR_BUSY, 8'h02});
    reader_on = 1'b1;
    repeat (300) @(posedge clk_in);
    done("timeout and busy");
    host.send('{8'h00, 8'h4b, 8'h01, 8'h00});
    reply('{8'h00, 8'h8b, 8'h01, 8'h00});
    chk("mode", 8'h00, mode);
    host.send('{8'h00, 8'h09, 8'h01, 8'h09});
    reply('{8'h00, 8'h99, 8'h02, ERR_NO_LINK, 8'h00});
    host.send('{8'h00, 8'h4b, 8'h01, 8'h88});
    reply('{8'h00, 8'h8b, 8'h01, 8'h00});
    chk("mode", 8'h88, mode);
    @(negedge clk_in);
    irq_seen = 1'b0;
    host.send('{8'h00, 8'h1b, 8'h01, 8'h00});
    reply('{8'h00, 8'h8b, 8'h01, 8'h00});
    chk("mode", 8'h88, mode);
    chk("interrupt seen", 1'b1, irq_seen);
    done("mode");
    slow = 1'b1;
    host.send('{8'h00, 8'h0a, 8'h01, 8'h00});
    reply('{8'h00, 8'h9a, 8'h02, ERR_NO_DATA, 8'h00});
    tsend(8'h3c);
    repeat (20) @(posedge clk_in);
    host.send('{8'h00, 8'h0a, 8'h01, 8'h00});
    reply('{8'h00, 8'h8a, 8'h01, 8'h3c});
    slow = 1'b0;
    host.send('{8'h00, 8'h6a, 8'h01, 8'h00});
    repeat (20) @(posedge clk_in);
    chk("reply count", 0, host.got_q.size());
    tsend(8'hc3);
    reply('{8'h00, 8'h8a, 8'h01, 8'hc3});
    done("read");
    host.send('{8'h00, 8'h8a, 8'h01, 8'h00});
    reply('{8'h00, 8'h9a, 8'h01, ERR_NO_LINK});
    host.send('{8'h00, 8'h0c, 8'h01, 8'h00});
    reply('{8'h00, 8'h9c, 8'h01, ERR_NO_LINK});
    chk("mode", 8'h88, mode);
    done("unknown op");
    wrap_up();
  end
endmodule
bind link_cmd_engine link_cmd_props props (.clk_in, .rst_in, .host_rx_in,
  .host_rx_ready_out, .host_tx_out, .host_tx_ready_in, .target_byte_ready_in,
  .target_byte_in, .target_byte_ack_out, .host_byte_taken_in, .block_wr_out,
  .target_irq_out, .mode_out, .block_addr_out, .status_out);
`default_nettype wire
